// ===== core/dpdrc_core.sv
`timescale 1ns/10ps
// Summary of operation
// - enter power-down on CKE low with NOP
// - row, precharge, refresh work finishes in power-down
// - recovery cycles come from three-bit field
// - entry disables buffers except clock, CKE, ODT, reset
// - open bank gives active, else precharge power-down
// - exit bit picks DLL kept on or off in precharge power-down; active keeps it on
// - reset low leaves power-down at once
// - exit on CKE high with NOP
// - slow exit makes ODT asynchronous around precharge power-down only
// - reset low disables outputs and termination
// - reset clears refresh counter, data unknown
module dpdrc_core
   import dpdrc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reset_n_pin,
   input wire logic cke_pin,
   input wire dpdrc_req_t req,
   input wire logic [2:0] write_recovery,
   input wire logic slow_exit_off,
   input wire logic dll_locked,
   output dpdrc_stat_t status,
   output logic [15:0] refresh_count,
   output logic odt_enable,
   output logic out_enable
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // two stages each; the first stage feeds only the second
   logic rstn_s1_r;
   logic rstn_s2_r;
   logic cke_s1_r;
   logic cke_s2_r;
   logic cke_prev_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rstn_s1_r <= 1'b0;
         rstn_s2_r <= 1'b0;
         cke_s1_r <= 1'b0;
         cke_s2_r <= 1'b0;
      end else begin
         rstn_s1_r <= reset_n_pin;
         rstn_s2_r <= rstn_s1_r;
         cke_s1_r <= cke_pin;
         cke_s2_r <= cke_s1_r;
      end
   end

   // ----------------------------------------
   // state and decode
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPDRC_RESET, DPDRC_IDLE, DPDRC_ENTERING, DPDRC_ACT_PD, DPDRC_PRE_PD
   } dpdrc_state_t;

   dpdrc_state_t state_r;
   dpdrc_state_t state_nxt;
   logic [DPDRC_NUM_BANKS-1:0] open_r;
   logic [DPDRC_NUM_BANKS-1:0] open_nxt;
   logic dll_off_r;
   logic odt_async_r;
   logic buf_on_r;
   logic [15:0] ref_cnt_r;
   logic [7:0] desel_r;
   logic [7:0] xpdll_r;

   wire in_reset = !rstn_s2_r;
   wire is_nop = req.cmd == DPDRC_CMD_NOP;
   wire cke_fall = cke_prev_r && !cke_s2_r;
   wire cke_rise = !cke_prev_r && cke_s2_r;
   wire enter_pd = state_r == DPDRC_IDLE && cke_fall && is_nop;
   wire exit_pd = (state_r == DPDRC_ACT_PD || state_r == DPDRC_PRE_PD ||
                   state_r == DPDRC_ENTERING) && cke_rise && is_nop;
   wire accept_cmd = state_r == DPDRC_IDLE && cke_s2_r;
   wire do_act = accept_cmd && req.cmd == DPDRC_CMD_ACT;
   wire do_pre = accept_cmd && (req.cmd == DPDRC_CMD_PRE ||
                 ((req.cmd == DPDRC_CMD_RD || req.cmd == DPDRC_CMD_WR)
                  && req.auto_close));
   wire do_ref = accept_cmd && req.cmd == DPDRC_CMD_REF;
   wire [DPDRC_NUM_BANKS-1:0] bank_bit = DPDRC_NUM_BANKS'(1) << req.bank;
   wire slow_pd = !slow_exit_off;
   // an auto-close write keeps the bank busy through write recovery too
   wire wr_close = accept_cmd && req.cmd == DPDRC_CMD_WR && req.auto_close;
   wire [7:0] act_load = wr_close ?
      DPDRC_ACTIVITY_CYC + {5'h00, write_recovery} :
      DPDRC_ACTIVITY_CYC;

   // ----------------------------------------
   // in-flight work timers
   // ----------------------------------------
   // activity and refresh keep running after CKE drops
   logic act_busy;
   logic ref_busy;
   dpdrc_timer #(.W(DPDRC_CNT_W)) u_act_tmr (
      .clock(clock),
      .rst(rst),
      .load(do_act || do_pre),
      .value(act_load),
      .busy(act_busy)
   );
   dpdrc_timer #(.W(DPDRC_CNT_W)) u_ref_tmr (
      .clock(clock),
      .rst(rst),
      .load(do_ref),
      .value(DPDRC_REFRESH_CYC),
      .busy(ref_busy)
   );

   assign open_nxt = do_act ? (open_r | bank_bit) :
                     (do_pre && req.cmd == DPDRC_CMD_PRE) ? '0 :
                     do_pre ? (open_r & ~bank_bit) : open_r;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DPDRC_RESET: begin
            if (!in_reset && !cke_s2_r) begin
               state_nxt = DPDRC_IDLE;
            end
         end
         DPDRC_IDLE: begin
            if (enter_pd) begin
               state_nxt = DPDRC_ENTERING;
            end
         end
         DPDRC_ENTERING: begin
            if (exit_pd) begin
               state_nxt = DPDRC_IDLE;
            end else if (!act_busy && !ref_busy) begin
               // mode settles once in-flight work is done
               state_nxt = (open_r != '0) ? DPDRC_ACT_PD
                                          : DPDRC_PRE_PD;
            end
         end
         DPDRC_ACT_PD, DPDRC_PRE_PD: begin
            if (exit_pd) begin
               state_nxt = DPDRC_IDLE;
            end
         end
         default: state_nxt = DPDRC_RESET;
      endcase
      if (in_reset) begin
         state_nxt = DPDRC_RESET;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= DPDRC_RESET;
         cke_prev_r <= 1'b0;
         open_r <= '0;
         ref_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cke_prev_r <= cke_s2_r;
         open_r <= in_reset ? '0 : open_nxt;
         // counter wiped on reset so refresh restarts from row zero
         ref_cnt_r <= in_reset ? '0 :
                      (do_ref ? ref_cnt_r + 16'h0001 : ref_cnt_r);
      end
   end

   // buffers drop after the deselect window; reset kills them at once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         buf_on_r <= 1'b0;
         desel_r <= DPDRC_ZERO;
      end else begin
         desel_r <= enter_pd ? DPDRC_DESEL_CYC :
                    (desel_r != DPDRC_ZERO ? desel_r - 8'h01 : desel_r);
         if (in_reset || (state_r != DPDRC_IDLE && state_r != DPDRC_RESET
                          && desel_r == DPDRC_ZERO)) begin
            buf_on_r <= 1'b0;
         end else if (state_r == DPDRC_IDLE) begin
            buf_on_r <= 1'b1;
         end
      end
   end

   // DLL off only in slow precharge power-down; ODT stays async until
   // the DLL relock period after exit has passed
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dll_off_r <= 1'b0;
         odt_async_r <= 1'b0;
         xpdll_r <= DPDRC_ZERO;
      end else begin
         dll_off_r <= state_nxt == DPDRC_PRE_PD && slow_pd;
         if (enter_pd && slow_pd && open_nxt == '0) begin
            odt_async_r <= 1'b1;
         end else if (exit_pd && odt_async_r) begin
            xpdll_r <= DPDRC_XPDLL_CYC + DPDRC_ODT_LEAD_CYC;
         end else if (xpdll_r == 8'h01 || in_reset) begin
            odt_async_r <= 1'b0;
            xpdll_r <= DPDRC_ZERO;
         end else if (xpdll_r != DPDRC_ZERO) begin
            xpdll_r <= xpdll_r - 8'h01;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status <= '0;
         refresh_count <= 16'h0000;
         odt_enable <= 1'b0;
         out_enable <= 1'b0;
      end else begin
         status.in_pd <= state_r == DPDRC_ENTERING ||
                         state_r == DPDRC_ACT_PD ||
                         state_r == DPDRC_PRE_PD;
         status.active_pd <= state_r == DPDRC_ACT_PD;
         status.dll_on <= !dll_off_r && dll_locked;
         status.odt_async <= odt_async_r;
         status.buffers_on <= buf_on_r;
         status.in_reset <= state_r == DPDRC_RESET;
         refresh_count <= ref_cnt_r;
         odt_enable <= !in_reset && state_r != DPDRC_RESET;
         out_enable <= buf_on_r && !in_reset;
      end
   end

endmodule

// ===== core/dpdrc_pkg.sv
package dpdrc_pkg;

   // ----------------------------------------
   // command encodings seen on the bus
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPDRC_CMD_NOP, DPDRC_CMD_ACT, DPDRC_CMD_PRE, DPDRC_CMD_REF,
      DPDRC_CMD_MRS, DPDRC_CMD_RD, DPDRC_CMD_WR, DPDRC_CMD_OTHER
   } dpdrc_cmd_t;

   typedef struct packed {
      dpdrc_cmd_t cmd;
      logic auto_close;
      logic [2:0] bank;
   } dpdrc_req_t;

   typedef struct packed {
      logic in_pd;
      logic active_pd;
      logic dll_on;
      logic odt_async;
      logic buffers_on;
      logic in_reset;
   } dpdrc_stat_t;

   // ----------------------------------------
   // counts and reset values
   // ----------------------------------------
   localparam int DPDRC_NUM_BANKS = 8;
   localparam int DPDRC_CNT_W = 8;
   localparam logic [7:0] DPDRC_ACTIVITY_CYC = 8'h10;
   localparam logic [7:0] DPDRC_REFRESH_CYC = 8'h40;
   localparam logic [7:0] DPDRC_DESEL_CYC = 8'h01;
   localparam logic [7:0] DPDRC_ODT_LEAD_CYC = 8'h01;
   localparam int DPDRC_CLK_PS = 100000;
   localparam int DPDRC_DLL_MIN_TCK = 10;
   localparam int DPDRC_DLL_MIN_PS = 24000;
   localparam int DPDRC_DLL_NS_CYC = (DPDRC_DLL_MIN_PS + DPDRC_CLK_PS - 1)
                                     / DPDRC_CLK_PS;
   localparam logic [7:0] DPDRC_XPDLL_CYC =
      8'(DPDRC_DLL_MIN_TCK > DPDRC_DLL_NS_CYC ? DPDRC_DLL_MIN_TCK
                                              : DPDRC_DLL_NS_CYC);
   localparam logic [7:0] DPDRC_ZERO = 8'h00;

endpackage

// ===== core/dpdrc_timer.sv
`timescale 1ns/10ps
module dpdrc_timer
   import dpdrc_pkg::*;
#(
   parameter int W = DPDRC_CNT_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic busy
);
   // loadable down counter; busy while non-zero
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   assign cnt_nxt = load ? value : (cnt_r != '0 ? cnt_r - 1'b1 : cnt_r);
   assign busy = cnt_r != '0;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ===== verif/dpdrc_core_checker.sv
`timescale 1ns/10ps
module dpdrc_core_checker
   import dpdrc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reset_n_pin,
   input wire logic cke_pin,
   input wire dpdrc_req_t req,
   input wire logic slow_exit_off,
   input wire dpdrc_stat_t status,
   input wire logic [15:0] refresh_count,
   input wire logic odt_enable,
   input wire logic out_enable
);
   // ----------------------------------------
   // device side checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_entry_cke_low: assert property (
      $rose(status.in_pd) |-> !$past(cke_pin, 2)) else $error("bad entry");
   a_reset_state: assert property (
      !reset_n_pin [*5] |=> status.in_reset && !odt_enable)
      else $error("reset state missed");
   a_reset_leave_pd: assert property (
      !reset_n_pin [*5] |=> !status.in_pd && !out_enable)
      else $error("reset kept power-down");
   a_reset_clear: assert property (
      status.in_reset [*2] |-> refresh_count == 16'h0000)
      else $error("refresh count kept");
   a_active_dll: assert property (
      status.active_pd |-> status.dll_on) else $error("dll off in active");
   a_fast_dll: assert property (
      status.in_pd && !status.dll_on |-> !slow_exit_off)
      else $error("dll off in fast exit");
   a_odt_async: assert property (
      (status.in_pd && !status.dll_on) [*2] |-> status.odt_async)
      else $error("odt not async");
   a_buffers_off: assert property (
      $rose(status.in_pd) |-> ##[1:80] !status.buffers_on)
      else $error("buffers stayed on");
   a_exit_nop: assert property (
      status.in_pd && $rose(cke_pin) && req.cmd == DPDRC_CMD_NOP
      |-> ##[1:6] !status.in_pd) else $error("no exit");
   c_active: cover property (status.active_pd);
   c_slow: cover property (status.in_pd && !status.dll_on);
   c_reset: cover property (status.in_reset && !reset_n_pin);
endmodule

// ===== verif/dpdrc_ctrl_model.sv
`timescale 1ns/10ps
module dpdrc_ctrl_model
   import dpdrc_pkg::*;
#(
   parameter int READ_LATENCY = 5,
   parameter int WRITE_LATENCY = 5,
   parameter int WRITE_RECOVERY = 5,
   parameter int MODE_SET_DELAY = 12
) (
   input wire logic clock,
   input wire logic sleep,
   input wire logic hold_reset,
   input wire dpdrc_cmd_t cmd,
   input wire logic auto_close,
   output logic cke_pin,
   output logic reset_n_pin,
   output dpdrc_req_t req
);
   // one down-counter spaces every transition; longer waits stay legal
   logic [7:0] gap_r = 8'h00;
   logic [7:0] cmd_gap;
   initial cke_pin = 1'b0;
   initial reset_n_pin = 1'b1;
   initial req = '0;
   // CKE stays high until a read, write or mode set's own work is over
   always_comb begin
      case (cmd)
         DPDRC_CMD_RD: cmd_gap = 8'(READ_LATENCY + 4 + 1);
         DPDRC_CMD_WR: cmd_gap = 8'(WRITE_LATENCY + 4 + WRITE_RECOVERY +
                                    (auto_close ? 1 : 0));
         DPDRC_CMD_MRS: cmd_gap = 8'(MODE_SET_DELAY);
         default: cmd_gap = 8'h02;
      endcase
   end
   always @(posedge clock) begin
      reset_n_pin <= !hold_reset;
      if (hold_reset) begin
         // low before release and a while after it
         cke_pin <= 1'b0;
         req <= '0;
         gap_r <= 8'h04;
      end else if (gap_r != 8'h00) begin
         req <= '0; // nop between commands
         gap_r <= gap_r - 8'h01;
      end else if (cke_pin && sleep) begin
         cke_pin <= 1'b0;
         req <= '0;
         gap_r <= 8'h04;
      end else if (!cke_pin && !sleep) begin
         cke_pin <= 1'b1;
         req <= '0;
         gap_r <= 8'h0A;
      end else if (cke_pin && cmd != DPDRC_CMD_NOP) begin
         req <= '{cmd: cmd, auto_close: auto_close, bank: 3'h0};
         gap_r <= cmd_gap;
      end else begin
         req <= '0;
      end
   end
endmodule

// ===== verif/dram_power_down_and_reset_control_test.sv
`timescale 1ns/10ps
module dram_power_down_and_reset_control_test;
   import dpdrc_pkg::*;
   logic clock, rst, sleep, hold_reset, slow_exit_off, dll_locked;
   logic cke_pin, reset_n_pin, odt_enable, out_enable;
   logic ac;
   logic [2:0] write_recovery;
   logic [15:0] refresh_count;
   dpdrc_cmd_t cmd;
   dpdrc_req_t req;
   dpdrc_stat_t status;
   int mismatches, cmp_count;
   dpdrc_ctrl_model ctrl (.clock(clock), .sleep(sleep),
      .hold_reset(hold_reset), .cmd(cmd), .auto_close(ac),
      .cke_pin(cke_pin),
      .reset_n_pin(reset_n_pin), .req(req));
   dpdrc_core uut (.clock(clock), .rst(rst), .reset_n_pin(reset_n_pin),
      .cke_pin(cke_pin), .req(req), .write_recovery(write_recovery),
      .slow_exit_off(slow_exit_off), .dll_locked(dll_locked),
      .status(status), .refresh_count(refresh_count),
      .odt_enable(odt_enable), .out_enable(out_enable));
   task automatic chk(input string nm, input logic [15:0] exp,
                      input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic issue(input dpdrc_cmd_t c, input logic a);
      cmd <= c;
      ac <= a;
      cyc(1);
      cmd <= DPDRC_CMD_NOP;
      ac <= 1'b0;
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_pre(input logic fast);
      slow_exit_off <= fast;
      sleep <= 1'b1;
      cyc(90);
      chk("in_pd", 16'h0001, status.in_pd);
      chk("active_pd", 16'h0000, status.active_pd);
      chk("dll_on", {15'h0000, fast}, status.dll_on);
      chk("odt_async", {15'h0000, !fast}, status.odt_async);
      chk("buffers_on", 16'h0000, status.buffers_on);
      sleep <= 1'b0;
      cyc(14);
      chk("in_pd", 16'h0000, status.in_pd);
   endtask
   task automatic t_act;
      slow_exit_off <= 1'b0;
      issue(DPDRC_CMD_ACT, 1'b0);
      sleep <= 1'b1;
      cyc(90);
      chk("active_pd", 16'h0001, status.active_pd);
      chk("dll_on", 16'h0001, status.dll_on);
      sleep <= 1'b0;
      cyc(14);
      issue(DPDRC_CMD_PRE, 1'b0);
      cyc(80);
   endtask
   // write recovery stretches the entry: DLL still on 22 cycles after
   task automatic t_write_close;
      slow_exit_off <= 1'b0;
      issue(DPDRC_CMD_WR, 1'b1);
      sleep <= 1'b1;
      cyc(22);
      chk("dll_on", 16'h0001, status.dll_on);
      cyc(10);
      chk("in_pd", 16'h0001, status.in_pd);
      chk("active_pd", 16'h0000, status.active_pd);
      chk("dll_on", 16'h0000, status.dll_on);
      sleep <= 1'b0;
      cyc(14);
      chk("in_pd", 16'h0000, status.in_pd);
   endtask
   task automatic t_refresh;
      issue(DPDRC_CMD_REF, 1'b0);
      cyc(5);
      issue(DPDRC_CMD_REF, 1'b0);
      cyc(5);
      chk("refresh_count", 16'h0002, refresh_count);
      cyc(80);
   endtask
   task automatic t_reset_pd;
      sleep <= 1'b1;
      cyc(90);
      hold_reset <= 1'b1;
      cyc(6);
      chk("in_pd", 16'h0000, status.in_pd);
      chk("in_reset", 16'h0001, status.in_reset);
      chk("odt_enable", 16'h0000, odt_enable);
      chk("out_enable", 16'h0000, out_enable);
      chk("refresh_count", 16'h0000, refresh_count);
      hold_reset <= 1'b0;
      cyc(8);
      chk("in_reset", 16'h0000, status.in_reset);
      sleep <= 1'b0;
      cyc(14);
   endtask
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      sleep = 1'b0;
      // pin reset and CKE low from power-up so the device leaves reset
      hold_reset = 1'b1;
      cmd = DPDRC_CMD_NOP;
      ac = 1'b0;
      slow_exit_off = 1'b1;
      dll_locked = 1'b1; // locked at every entry, no DLL reset
      write_recovery = 3'h5;
      mismatches = 0;
      cmp_count = 0;
      cyc(2);
      rst <= 1'b0;
      hold_reset <= 1'b0;
      cyc(12);
      t_pre(1'b1);
      t_pre(1'b0);
      t_act;
      t_write_close;
      t_refresh;
      t_reset_pd;
      end_sim;
   end
   initial begin
      cyc(2000);
      mismatches++;
      end_sim;
   end
endmodule
bind dpdrc_core dpdrc_core_checker u_chk (.clock, .rst, .reset_n_pin,
   .cke_pin, .req, .slow_exit_off, .status, .refresh_count, .odt_enable,
   .out_enable);
